/* File: logic/scmc_map.svh */
`ifndef SCMC_MAP_SVH
`define SCMC_MAP_SVH

// register byte offsets on the apb window
`define SCMC_OFS_MODE       8'h00
`define SCMC_OFS_ADDR_CHAR  8'h04
`define SCMC_OFS_FLAG_CHAR  8'h08
`define SCMC_OFS_MISC_CTRL  8'h0c
`define SCMC_OFS_OPTIONS    8'h10
`define SCMC_OFS_STATUS     8'h14

// misc_mode_parameters field positions
`define SCMC_RATE_HI        7
`define SCMC_RATE_LO        6
`define SCMC_SYNC_HI        5
`define SCMC_SYNC_LO        4
`define SCMC_STOP_HI        3
`define SCMC_STOP_LO        2

// misc_tx_rx_control_reg and options bits
`define SCMC_MISC_SIX_BIT   1
`define SCMC_OPT_EXT_READ   0
`define SCMC_OPT_LOAD_INH   1
`define SCMC_OPT_EXT_SYNC   2

// reset values; stop field bit 2 comes up set
`define SCMC_MODE_RST       8'h04
`define SCMC_CHAR_RST       8'h00
`define SCMC_OPT_RST        3'h0

`define SCMC_STOP_SYNC      2'h0
`define SCMC_CHAR_BITS      4'h8

`endif

/* File: logic/scmc_pkg.sv */
package scmc_pkg;

  typedef enum logic [1:0] {
    SCMC_MONO,
    SCMC_BISYNC,
    SCMC_SDLC,
    SCMC_RESERVED
  } scmc_sync_sel_t;

  typedef enum logic [1:0] {
    SCMC_W6,
    SCMC_W8,
    SCMC_W12,
    SCMC_W16
  } scmc_width_t;

  typedef enum {
    SCMC_HUNT,
    SCMC_SYNCED
  } scmc_rx_state_t;

  typedef struct packed {
    logic [7:0]     mode;
    logic           mode_written;
    logic [7:0]     addr_char;
    logic [7:0]     flag_char;
    logic [7:0]     misc_ctrl;
    logic [2:0]     opt;
    logic [31:0]    rdata;
    logic           slverr;
    scmc_rx_state_t rx_state;
    logic [15:0]    rx_sh;
    logic [3:0]     rx_cnt;
    logic [7:0]     rx_char;
    logic           rx_valid;
    logic [15:0]    tx_sh;
    logic [3:0]     tx_cnt;
    logic           tx_bit;
  } scmc_state_t;

endpackage

/* File: logic/scmc_if.sv */
`timescale 1ns/1ps
interface scmc_if;
  import scmc_pkg::*;

  logic [15:0] window;
  logic [7:0]  flag_char;
  logic [7:0]  addr_char;
  scmc_width_t width;
  logic        match;

  modport hunter (
    output window,
    output flag_char,
    output addr_char,
    output width,
    input  match
  );

  modport matcher (
    input  window,
    input  flag_char,
    input  addr_char,
    input  width,
    output match
  );
endinterface

/* File: logic/scmc_sync_match.sv */
`timescale 1ns/1ps
module scmc_sync_match (
  scmc_if.matcher m
);
  import scmc_pkg::*;

  // newest bit sits at window[15]; the flag char arrives first, so it is the low part
  always_comb begin
    case (m.width)
      SCMC_W6:  m.match = (m.window[15:10] == m.flag_char[5:0]);
      SCMC_W8:  m.match = (m.window[15:8] == m.flag_char);
      SCMC_W12: m.match = (m.window[15:4] == {m.addr_char[5:0], m.flag_char[5:0]});
      SCMC_W16: m.match = (m.window == {m.addr_char, m.flag_char});
      default:  m.match = 1'b0;
    endcase
  end
endmodule

/* File: logic/scmc_top.sv */
// Overview of operation
// [RULE_01] clock rate field 00/01/10/11 selects 1X, 16X, 32X, 64X multiplier.
// [RULE_02] synchronous modes force 1X and ignore clock rate, unless external sync.
// [RULE_03] sync mode field only matters when stop bits field selects synchronous.
// [RULE_04] monosync receiver aligns on a character equal to sync_flag_char_reg.
// [RULE_05] monosync transmitter idles with sync_address_char_reg when no data waits.
// [RULE_06] monosync sync character is six or eight bits per misc_tx_rx_control_reg.
// [RULE_07] monosync with load inhibit drops received chars equal to sync_address_char_reg.
// [RULE_08] bisync uses flag char joined with address char for hunt and idle fill.
// [RULE_09] bisync receive pattern is 12 or 16 bits; transmit pattern always 16.
// [RULE_10] software loads flag 01111110 into sync_flag_char_reg before SDLC.
// [RULE_11] software places station address in sync_address_char_reg for SDLC search.
// [RULE_12] software picks SDLC crc polynomial in transmit_control_reg.
// [RULE_13] software never writes the reserved sync mode code 11.
// [RULE_14] software writes this mode register before the other channel registers.
// [RULE_15] with extended read on, reads return the written mode; otherwise write-only.
// [RULE_16] stop field 00 is synchronous and 1X; 01/10/11 async with 1, 1.5, 2 stops.
// [RULE_17] no mode is assumed until software has written the mode register.
`timescale 1ns/1ps
`include "scmc_map.svh"
module scmc_top (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               rx_bit,
  input  wire logic               rx_bit_valid,
  input  wire logic               rx_hunt,
  output logic [7:0]              rx_char,
  output logic                    rx_char_valid,
  output logic                    rx_synced,
  input  wire logic               tx_bit_req,
  input  wire logic [7:0]         tx_data,
  input  wire logic               tx_data_valid,
  output logic                    tx_data_ready,
  output logic                    tx_bit,
  output logic [6:0]              rate_mult,
  output logic                    sync_mode_on,
  output scmc_pkg::scmc_sync_sel_t sync_sel,
  output logic                    mode_valid
);
  import scmc_pkg::*;

  scmc_state_t s;
  scmc_state_t next_s;
  scmc_if      mif ();

  scmc_sync_match u_match (
    .m (mif.matcher)
  );

  logic [1:0]  stop_field;
  logic [1:0]  rate_field;
  logic [1:0]  rate_eff;
  logic        six_bit;
  logic        hunt_mode;
  logic        load_inh;
  logic        setup;
  logic        wr_access;
  logic        wr_mode;
  logic [15:0] rx_next_sh;
  logic [7:0]  rx_next_char;
  logic [15:0] fill_word;
  logic [3:0]  fill_len;
  logic [15:0] load_word;
  logic [3:0]  load_len;
  logic        tx_load;

  assign stop_field = s.mode[`SCMC_STOP_HI:`SCMC_STOP_LO];
  assign rate_field = s.mode[`SCMC_RATE_HI:`SCMC_RATE_LO];
  assign six_bit    = s.misc_ctrl[`SCMC_MISC_SIX_BIT];
  assign load_inh   = s.opt[`SCMC_OPT_LOAD_INH];
  assign mode_valid = s.mode_written;

  // until the first mode write the channel behaves as if asynchronous
  assign sync_mode_on = s.mode_written && (stop_field == `SCMC_STOP_SYNC); // [RULE_16] [RULE_17]

  // sync field is only honoured when the stop field selects synchronous
  always_comb begin
    if (sync_mode_on) begin
      sync_sel = scmc_sync_sel_t'(s.mode[`SCMC_SYNC_HI:`SCMC_SYNC_LO]); // [RULE_03]
    end else begin
      sync_sel = SCMC_RESERVED;
    end
  end

  // the reserved code neither hunts nor fills; it is treated as idle line
  assign hunt_mode = sync_mode_on && (sync_sel != SCMC_RESERVED);

  assign rate_eff = (sync_mode_on && !s.opt[`SCMC_OPT_EXT_SYNC]) ? 2'h0 : rate_field; // [RULE_02] [RULE_16]

  always_comb begin
    case (rate_eff)
      2'h0:    rate_mult = 7'h01; // [RULE_01]
      2'h1:    rate_mult = 7'h10; // [RULE_01]
      2'h2:    rate_mult = 7'h20; // [RULE_01]
      default: rate_mult = 7'h40; // [RULE_01]
    endcase
  end

  // apb: decode in setup, answer in the first access cycle
  assign setup     = psel && !penable;
  assign wr_access = psel && penable && pwrite && !s.slverr;
  assign wr_mode   = wr_access && (paddr == `SCMC_OFS_MODE);
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && s.slverr;
  assign prdata    = s.rdata;

  // hunt pattern width follows the sync mode and the six-bit option
  assign rx_next_sh     = {rx_bit, s.rx_sh[15:1]};
  assign rx_next_char   = rx_next_sh[15:8];
  assign mif.window     = rx_next_sh;
  assign mif.flag_char  = s.flag_char;
  assign mif.addr_char  = s.addr_char;

  always_comb begin
    case (sync_sel)
      SCMC_MONO:   mif.width = six_bit ? SCMC_W6 : SCMC_W8;   // [RULE_04] [RULE_06]
      SCMC_BISYNC: mif.width = six_bit ? SCMC_W12 : SCMC_W16; // [RULE_08] [RULE_09]
      default:     mif.width = SCMC_W8;
    endcase
  end

  // idle fill chosen per mode; async line idles at mark
  always_comb begin
    case (sync_sel)
      SCMC_MONO: begin
        fill_word = {8'h00, s.addr_char}; // [RULE_05]
        fill_len  = six_bit ? 4'h5 : 4'h7; // [RULE_06]
      end
      SCMC_BISYNC: begin
        fill_word = {s.addr_char, s.flag_char}; // [RULE_08]
        fill_len  = 4'hf; // [RULE_09]
      end
      SCMC_SDLC: begin
        fill_word = {8'h00, s.flag_char};
        fill_len  = 4'h7;
      end
      default: begin
        fill_word = 16'hffff;
        fill_len  = 4'h0;
      end
    endcase
  end

  assign tx_load       = tx_bit_req && (s.tx_cnt == 4'h0);
  // lengths count the bits still owed after the load bit, so sixteen fits in four bits
  assign tx_data_ready = tx_load && hunt_mode && tx_data_valid;

  always_comb begin
    if (tx_data_ready && tx_data_valid) begin
      load_word = {8'h00, tx_data};
      load_len  = `SCMC_CHAR_BITS - 4'h1;
    end else begin
      load_word = fill_word;
      load_len  = fill_len;
    end
  end

  always_comb begin
    next_s          = s;
    next_s.rx_valid = 1'b0;
    next_s.slverr   = 1'b0;

    if (setup) begin
      next_s.rdata  = 32'h0000_0000;
      next_s.slverr = 1'b0;
      case (paddr)
        `SCMC_OFS_MODE: begin
          if (s.opt[`SCMC_OPT_EXT_READ]) begin
            next_s.rdata = {24'h000000, s.mode}; // [RULE_15]
          end
        end
        `SCMC_OFS_ADDR_CHAR: next_s.rdata = {24'h000000, s.addr_char};
        `SCMC_OFS_FLAG_CHAR: next_s.rdata = {24'h000000, s.flag_char};
        `SCMC_OFS_MISC_CTRL: next_s.rdata = {24'h000000, s.misc_ctrl};
        `SCMC_OFS_OPTIONS:   next_s.rdata = {29'h00000000, s.opt};
        `SCMC_OFS_STATUS: begin
          next_s.rdata = {25'h0000000, (s.rx_state == SCMC_SYNCED), s.mode_written,
                          sync_mode_on, sync_sel, rate_eff};
          next_s.slverr = pwrite;
        end
        default: next_s.slverr = 1'b1;
      endcase
    end else if (psel && penable) begin
      next_s.slverr = s.slverr;
    end

    if (wr_access) begin
      case (paddr)
        `SCMC_OFS_MODE: begin
          next_s.mode         = pwdata[7:0];
          next_s.mode_written = 1'b1; // [RULE_17]
        end
        `SCMC_OFS_ADDR_CHAR: next_s.addr_char = pwdata[7:0];
        `SCMC_OFS_FLAG_CHAR: next_s.flag_char = pwdata[7:0];
        `SCMC_OFS_MISC_CTRL: next_s.misc_ctrl = pwdata[7:0];
        `SCMC_OFS_OPTIONS:   next_s.opt = pwdata[2:0];
        default: begin
        end
      endcase
    end

    // receiver hunt and character framing
    if (rx_bit_valid) begin
      next_s.rx_sh = rx_next_sh;
    end
    case (s.rx_state)
      SCMC_HUNT: begin
        if (rx_bit_valid && hunt_mode && mif.match) begin
          next_s.rx_state = SCMC_SYNCED; // [RULE_04] [RULE_08]
          next_s.rx_cnt   = 4'h0;
        end
      end
      SCMC_SYNCED: begin
        if (rx_bit_valid) begin
          if (sync_sel == SCMC_SDLC && mif.match) begin
            // flags realign framing and are never data
            next_s.rx_cnt = 4'h0;
          end else if (s.rx_cnt == `SCMC_CHAR_BITS - 4'h1) begin
            next_s.rx_cnt = 4'h0;
            // compare is always eight bits wide
            if (!(sync_sel == SCMC_MONO && load_inh && rx_next_char == s.addr_char)) begin // [RULE_07]
              next_s.rx_char  = rx_next_char;
              next_s.rx_valid = 1'b1;
            end
          end else begin
            next_s.rx_cnt = s.rx_cnt + 4'h1;
          end
        end
      end
      default: next_s.rx_state = SCMC_HUNT;
    endcase
    // a mode change invalidates alignment
    if (rx_hunt || wr_mode || !hunt_mode) begin
      next_s.rx_state = SCMC_HUNT;
      next_s.rx_cnt   = 4'h0;
    end

    // transmitter shifts lsb first, one bit per request
    if (tx_load) begin
      next_s.tx_bit = load_word[0];
      next_s.tx_sh  = {1'b0, load_word[15:1]};
      next_s.tx_cnt = load_len;
    end else if (tx_bit_req) begin
      next_s.tx_bit = s.tx_sh[0];
      next_s.tx_sh  = {1'b0, s.tx_sh[15:1]};
      next_s.tx_cnt = s.tx_cnt - 4'h1;
    end
  end

  // bisync loads a count of 15 after its first bit, giving sixteen bits in all
  always_ff @(posedge clk) begin
    if (rst) begin
      s              <= '0;
      s.mode         <= `SCMC_MODE_RST;
      s.addr_char    <= `SCMC_CHAR_RST;
      s.flag_char    <= `SCMC_CHAR_RST;
      s.misc_ctrl    <= `SCMC_CHAR_RST;
      s.opt          <= `SCMC_OPT_RST;
      s.rx_state     <= SCMC_HUNT;
      s.tx_bit       <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign rx_char       = s.rx_char;
  assign rx_char_valid = s.rx_valid;
  assign rx_synced     = (s.rx_state == SCMC_SYNCED);
  assign tx_bit        = s.tx_bit;

endmodule

/* File: testbench/scmc_monitor.sv */
`timescale 1ns/1ps
module scmc_monitor (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [7:0]               paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire logic                     rx_bit,
  input wire logic                     rx_bit_valid,
  input wire logic                     rx_hunt,
  input wire logic [7:0]               rx_char,
  input wire logic                     rx_char_valid,
  input wire logic                     rx_synced,
  input wire logic                     tx_bit_req,
  input wire logic [7:0]               tx_data,
  input wire logic                     tx_data_valid,
  input wire logic                     tx_data_ready,
  input wire logic                     tx_bit,
  input wire logic [6:0]               rate_mult,
  input wire logic                     sync_mode_on,
  input wire scmc_pkg::scmc_sync_sel_t sync_sel,
  input wire logic                     mode_valid
);
  import scmc_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_RATE_SET: assert property (rate_mult inside {7'h01, 7'h10, 7'h20, 7'h40})
    else $error("rate multiplier illegal");
  AST_ASYNC_SEL: assert property (!sync_mode_on |-> sync_sel == SCMC_RESERVED)
    else $error("sync select active in async mode");
  AST_SYNC_WRITTEN: assert property (sync_mode_on |-> mode_valid)
    else $error("sync mode before mode write");
  AST_IDLE_ONES: assert property (!mode_valid && tx_bit_req |=> tx_bit)
    else $error("unconfigured line not idle high");
  AST_TX_HOLD: assert property (!tx_bit_req |=> $stable(tx_bit))
    else $error("tx bit moved without request");
  AST_READY_GATE: assert property (tx_data_ready |-> tx_bit_req && tx_data_valid && sync_mode_on)
    else $error("tx data taken without cause");
  AST_CHAR_CAUSE: assert property (rx_char_valid |-> $past(rx_bit_valid) && $past(rx_synced))
    else $error("char without aligned bit");
  AST_HUNT_ASYNC: assert property (!sync_mode_on ##1 !sync_mode_on |-> !rx_synced)
    else $error("aligned while async");
  COV_SYNCED: cover property ($rose(rx_synced));
  COV_CHAR: cover property (rx_char_valid);
  COV_TX_LOAD: cover property (tx_data_ready);
endmodule
bind scmc_top scmc_monitor mon (.*);

/* File: testbench/scmc_station.sv */
`timescale 1ns/1ps
module scmc_station (
  input  wire logic clk,
  output logic      rx_bit,
  output logic      rx_bit_valid,
  output logic      tx_bit_req,
  input  wire logic tx_bit
);
  logic [15:0] heard;
  initial begin
    rx_bit = 1'b0;
    rx_bit_valid = 1'b0;
    tx_bit_req = 1'b0;
    heard = 16'h0;
  end
  // in gap cycles between bits the line shows the inverse with valid low, so a stale bit never passes as fresh
  task automatic send(input logic [15:0] v, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rx_bit <= v[i];
      rx_bit_valid <= 1'b1;
      repeat (gap) begin
        @(posedge clk);
        rx_bit <= ~v[i];
        rx_bit_valid <= 1'b0;
      end
    end
    @(posedge clk);
    rx_bit <= ~v[n-1];
    rx_bit_valid <= 1'b0;
  endtask
  task automatic listen(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      tx_bit_req <= 1'b1;
      @(posedge clk);
      tx_bit_req <= 1'b0;
      repeat (gap) @(posedge clk);
      @(posedge clk);
      heard[i] = tx_bit;
    end
  endtask
endmodule

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`include "scmc_map.svh"
module tb;
  import scmc_pkg::*;
  logic           clk, rst, psel, penable, pwrite, rx_bit, rx_bit_valid, rx_hunt;
  logic           tx_bit_req, tx_data_valid, tx_data_ready, tx_bit, rx_char_valid;
  logic           rx_synced, pready, pslverr, sync_mode_on, mode_valid, re;
  logic [7:0]     paddr, tx_data, rx_char;
  logic [31:0]    pwdata, prdata, rv;
  logic [6:0]     rate_mult;
  scmc_sync_sel_t sync_sel;
  int             failures, comparisons;
  logic [7:0]     got[$];
  scmc_top dut (.*);
  scmc_station st (.clk(clk), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .tx_bit_req(tx_bit_req), .tx_bit(tx_bit));
  always #25 clk = ~clk;
  always @(posedge clk) if (rx_char_valid === 1'b1) got.push_back(rx_char);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // no wait-state count is assumed; the loop bound only guards a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      failures++;
      complete_run();
    end
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // outputs are looked at mid-cycle, once the completing edge has settled
    @(negedge clk);
  endtask
  task automatic t_reset();
    st.listen(2, 0);
    chk("idle ones", st.heard[1:0], 2'h3);
    apb(1'b0, `SCMC_OFS_STATUS, 32'h0);
    chk("status", rv, 32'h0000000c);
    chk("mode_valid", mode_valid, 1'b0);
    apb(1'b0, `SCMC_OFS_MODE, 32'h0);
    chk("mode hidden", rv, 32'h0);
    apb(1'b1, `SCMC_OFS_STATUS, 32'hff);
    chk("status write err", re, 1'b1);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped err", re, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_tx();
    apb(1'b1, `SCMC_OFS_MODE, 32'h00);
    apb(1'b1, `SCMC_OFS_ADDR_CHAR, 32'h3c);
    apb(1'b1, `SCMC_OFS_FLAG_CHAR, 32'h16);
    st.listen(8, 0);
    chk("mono fill", st.heard[7:0], 8'h3c);
    @(posedge clk);
    tx_data <= 8'h96;
    tx_data_valid <= 1'b1;
    st.listen(8, 2);
    tx_data_valid <= 1'b0;
    chk("tx data", st.heard[7:0], 8'h96);
    apb(1'b1, `SCMC_OFS_MISC_CTRL, 32'h2);
    apb(1'b1, `SCMC_OFS_MODE, 32'h10);
    st.listen(16, 0);
    chk("bisync fill", st.heard, 16'h3c16);
    apb(1'b1, `SCMC_OFS_MODE, 32'h20);
    apb(1'b1, `SCMC_OFS_FLAG_CHAR, 32'h7e);
    apb(1'b1, `SCMC_OFS_ADDR_CHAR, 32'h3c);
    st.listen(8, 0);
    chk("sdlc fill", st.heard[7:0], 8'h7e);
    apb(1'b1, `SCMC_OFS_MODE, 32'h00);
    apb(1'b1, `SCMC_OFS_FLAG_CHAR, 32'h16);
    st.listen(6, 0);
    chk("six bit fill", st.heard[5:0], 6'h3c);
    $display("test transmit done");
  endtask
  task automatic t_modes();
    logic [7:0] m;
    apb(1'b1, `SCMC_OFS_OPTIONS, 32'h1);
    for (int r = 0; r < 4; r++) begin
      m = {r[1:0], 2'h1, 2'(r % 3 + 1), 2'h0};
      apb(1'b1, `SCMC_OFS_MODE, {24'h0, m});
      apb(1'b0, `SCMC_OFS_MODE, 32'h0);
      chk("readback", rv, {24'h0, m});
      chk("rate", rate_mult, 7'h1 << (r == 0 ? 0 : r + 3));
      chk("async sel", sync_sel, SCMC_RESERVED);
    end
    apb(1'b1, `SCMC_OFS_MODE, 32'hd0);
    chk("forced 1x", rate_mult, 7'h1);
    chk("bisync sel", sync_sel, SCMC_BISYNC);
    apb(1'b1, `SCMC_OFS_OPTIONS, 32'h5);
    chk("ext sync rate", rate_mult, 7'h40);
    $display("test modes done");
  endtask
  task automatic t_rx();
    apb(1'b1, `SCMC_OFS_MISC_CTRL, 32'h0);
    apb(1'b1, `SCMC_OFS_MODE, 32'h00);
    apb(1'b1, `SCMC_OFS_OPTIONS, 32'h2);
    st.send(16'h16, 8, 0);
    repeat (2) @(posedge clk);
    chk("mono synced", rx_synced, 1'b1);
    got.delete();
    st.send(16'h3c, 8, 0);
    st.send(16'ha5, 8, 2);
    repeat (3) @(posedge clk);
    chk("kept chars", got.size(), 1);
    chk("mono char", got[0], 8'ha5);
    rx_hunt <= 1'b1;
    @(posedge clk);
    rx_hunt <= 1'b0;
    repeat (2) @(posedge clk);
    chk("hunt", rx_synced, 1'b0);
    apb(1'b1, `SCMC_OFS_MISC_CTRL, 32'h2);
    apb(1'b1, `SCMC_OFS_MODE, 32'h10);
    st.send(16'h0f16, 12, 1);
    repeat (2) @(posedge clk);
    chk("bisync 12 synced", rx_synced, 1'b1);
    apb(1'b1, `SCMC_OFS_MODE, 32'h04);
    st.send(16'h16, 8, 0);
    repeat (2) @(posedge clk);
    chk("async no hunt", rx_synced, 1'b0);
    $display("test receive done");
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {rx_hunt, tx_data, tx_data_valid} = '0;
    failures = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_tx();
    t_modes();
    t_rx();
    complete_run();
  end
endmodule
